/* srw_top.sv */
// supervisor: reset generation, watchdog, power-fail flag, ram supply select
// What this block does
// - watchdog expiry after steady input triggers reset
// - any kick edge clears the watchdog timer
// - watchdog held cleared during reset, counts after
// - steady kick gives pulses every period plus hold
// - watchdog cannot be disabled outside backup
// - triggered reset lasts reset hold time
// - reset held by low supply/manual, then extended
// - each supply drop restarts hold timer
// - manual reset idle high, bounce tolerated
// - open-drain active-high reset is inverse
// - power-fail flag follows sense comparison
// - below switchover flag forced low, comparison off
// - backup selected below switchover and backup, or minimum
// - return to main only above reset level
// - no backup entry while supply above switchover, unless below minimum
// - backup disables watchdog, manual; reset held
`timescale 1ns/1ns
module srw_top
    import srw_pkg::*;
#(
    parameter int WDOG_CYC = SRW_WDOG_CYC,
    parameter int HOLD_CYC = SRW_HOLD_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic supply_below_reset_in,
    input  wire logic supply_below_switchover_in,
    input  wire logic supply_below_backup_in,
    input  wire logic supply_below_minimum_in,
    input  wire logic powerfail_sense_in,
    input  wire logic watchdog_kick_in,
    input  wire logic manual_reset_n,
    output logic      reset_out_n,
    output logic      reset_high_out,
    output logic      reset_high_oe_n,
    output logic      powerfail_flag_n,
    output logic      ram_supply_out
);
    typedef enum logic [1:0] {
        SRW_ST_HOLD   = 2'b00,
        SRW_ST_EXTEND = 2'b01,
        SRW_ST_RUN    = 2'b10,
        SRW_ST_BACKUP = 2'b11
    } srw_state_t;

    logic below_rst;
    logic below_sw;
    logic below_bat;
    logic below_min;
    logic pf_sense;
    logic kick;
    logic mr_n;

    // all pin-level comparator results pass the 3-flop filter
    srw_sync #(.RESET_VAL(1'b1)) u_sync_rst (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (supply_below_reset_in),
        .level_out (below_rst)
    );
    srw_sync #(.RESET_VAL(1'b1)) u_sync_sw (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (supply_below_switchover_in),
        .level_out (below_sw)
    );
    srw_sync #(.RESET_VAL(1'b1)) u_sync_bat (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (supply_below_backup_in),
        .level_out (below_bat)
    );
    srw_sync #(.RESET_VAL(1'b1)) u_sync_min (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (supply_below_minimum_in),
        .level_out (below_min)
    );
    srw_sync #(.RESET_VAL(1'b0)) u_sync_pf (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (powerfail_sense_in),
        .level_out (pf_sense)
    );
    srw_sync #(.RESET_VAL(1'b0)) u_sync_kick (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (watchdog_kick_in),
        .level_out (kick)
    );
    // pull-up makes an open pin read high; bounce only restarts the hold
    srw_sync #(.RESET_VAL(1'b1)) u_sync_mr (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (manual_reset_n),
        .level_out (mr_n)
    );

    srw_state_t state_reg;
    srw_state_t state_next;
    logic       kick_prev_reg;
    logic       kick_prev_next;
    logic       backup_reg;
    logic       backup_next;
    logic       pfo_reg;
    logic       pfo_next;
    logic       rst_n_reg;
    logic       rst_n_next;

    logic       kick_edge;
    logic       hold_load;
    logic       hold_done;
    logic       wd_load;
    logic       wd_run;
    logic       wd_done;

    assign kick_edge = kick ^ kick_prev_reg;

    srw_timer #(.CNT_W(SRW_CNT_W)) u_hold (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (hold_load),
        .load_val (SRW_CNT_W'(HOLD_CYC)),
        .run      (state_reg == SRW_ST_EXTEND),
        .done     (hold_done)
    );

    srw_timer #(.CNT_W(SRW_CNT_W)) u_wdog (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (wd_load),
        .load_val (SRW_CNT_W'(WDOG_CYC)),
        .run      (wd_run),
        .done     (wd_done)
    );

    always_comb begin
        state_next     = state_reg;
        hold_load      = 1'b0;
        wd_load        = 1'b0;
        wd_run         = 1'b0;
        kick_prev_next = kick;
        backup_next    = backup_reg;
        // backup entry below switchover and backup, or below minimum; exit only above reset level
        if (below_min) begin
            backup_next = 1'b1;
        end else if (below_sw && below_bat) begin
            backup_next = 1'b1;
        end else if (!below_rst) begin
            backup_next = 1'b0;
        end
        // comparison gated off below switchover level
        pfo_next = below_sw ? 1'b0 : pf_sense;
        unique case (state_reg)
            SRW_ST_HOLD: begin
                hold_load = 1'b1;
                wd_load   = 1'b1;
                if (backup_reg) begin
                    state_next = SRW_ST_BACKUP;
                end else if (!below_rst && mr_n) begin
                    state_next = SRW_ST_EXTEND;
                end
            end
            SRW_ST_EXTEND: begin
                wd_load = 1'b1;
                if (backup_reg) begin
                    state_next = SRW_ST_BACKUP;
                end else if (below_rst || !mr_n) begin
                    state_next = SRW_ST_HOLD;
                end else if (hold_done) begin
                    state_next = SRW_ST_RUN;
                end
            end
            SRW_ST_RUN: begin
                // always counting here; there is no disable path
                wd_run  = 1'b1;
                wd_load = kick_edge;
                if (backup_reg) begin
                    state_next = SRW_ST_BACKUP;
                end else if (below_rst || !mr_n) begin
                    state_next = SRW_ST_HOLD;
                end else if (wd_done && !kick_edge) begin
                    // expiry reloads hold, so pulses repeat
                    hold_load  = 1'b1;
                    state_next = SRW_ST_EXTEND;
                end
            end
            SRW_ST_BACKUP: begin
                // manual reset and watchdog ignored here
                hold_load = 1'b1;
                wd_load   = 1'b1;
                if (!backup_reg) begin
                    state_next = SRW_ST_HOLD;
                end
            end
        endcase
        // backup entry drops reset on the edge that sets backup_reg, a cycle before the state change
        rst_n_next = (state_next == SRW_ST_RUN) && !backup_next;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= SRW_ST_HOLD;
            kick_prev_reg <= 1'b0;
            backup_reg    <= SRW_BACKUP_RESET;
            pfo_reg       <= SRW_PFO_RESET;
            rst_n_reg     <= SRW_RST_N_RESET;
        end else begin
            state_reg     <= state_next;
            kick_prev_reg <= kick_prev_next;
            backup_reg    <= backup_next;
            pfo_reg       <= pfo_next;
            rst_n_reg     <= rst_n_next;
        end
    end

    assign reset_out_n      = rst_n_reg;
    // open drain: pull low only when reset is released
    assign reset_high_out   = 1'b0;
    assign reset_high_oe_n  = ~rst_n_reg;
    assign powerfail_flag_n = pfo_reg;
    assign ram_supply_out   = backup_reg;
endmodule

/* srw_pkg.sv */
// constants shared by the supervisor reset watchdog
package srw_pkg;
    localparam int    SRW_CLK_HZ       = 20_000_000;
    localparam int    SRW_WDOG_MS      = 1600;  // watchdog period, ms
    localparam int    SRW_HOLD_MS      = 200;   // reset_hold_time, ms
    // longest-time style counts round down
    localparam int    SRW_WDOG_CYC     = SRW_WDOG_MS * (SRW_CLK_HZ / 1000);
    localparam int    SRW_HOLD_CYC     = SRW_HOLD_MS * (SRW_CLK_HZ / 1000);
    localparam int    SRW_CNT_W        = 26;
    localparam int    SRW_SYNC_STAGES  = 3;
    localparam logic  SRW_RST_N_RESET  = 1'b0;
    localparam logic  SRW_PFO_RESET    = 1'b0;
    localparam logic  SRW_BACKUP_RESET = 1'b1;
endpackage

/* srw_sync.sv */
// three-stage pin synchroniser; change accepted when stages two and three agree
`timescale 1ns/1ns
module srw_sync
    import srw_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      level_out
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic       level_reg;
    logic       level_next;

    always_comb begin
        stage_next = {stage_reg[1:0], pin_in};
        level_next = level_reg;
        if (stage_reg[1] == stage_reg[2]) begin
            level_next = stage_reg[2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_reg <= {3{RESET_VAL}};
            level_reg <= RESET_VAL;
        end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign level_out = level_reg;
endmodule

/* srw_timer.sv */
// down counter: load, hold cleared, count, flag when expired
`timescale 1ns/1ns
module srw_timer
    import srw_pkg::*;
#(
    parameter int CNT_W = SRW_CNT_W
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_val,
    input  wire logic             run,
    output logic                  done
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = load_val;
        end else if (run && cnt_reg != '0) begin
            cnt_next = cnt_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign done = (cnt_reg == '0);
endmodule

/* srw_properties.sv */
// port assertions for the supervisor reset watchdog
`timescale 1ns/1ns
module srw_properties
    import srw_pkg::*;
#(
    parameter int WDOG_CYC = SRW_WDOG_CYC,
    parameter int HOLD_CYC = SRW_HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_below_reset_in,
    input wire logic supply_below_switchover_in,
    input wire logic supply_below_backup_in,
    input wire logic supply_below_minimum_in,
    input wire logic powerfail_sense_in,
    input wire logic watchdog_kick_in,
    input wire logic manual_reset_n,
    input wire logic reset_out_n,
    input wire logic reset_high_out,
    input wire logic reset_high_oe_n,
    input wire logic powerfail_flag_n,
    input wire logic ram_supply_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] low_cnt_reg;
    logic [15:0] calm_cnt_reg;
    logic        kick_reg;
    // cycles of reset low, and cycles since the last kick edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_reg  <= 16'h0000;
            calm_cnt_reg <= 16'h0000;
            kick_reg     <= 1'b0;
        end else begin
            low_cnt_reg  <= reset_out_n ? 16'h0000 : low_cnt_reg + 16'h0001;
            calm_cnt_reg <= (watchdog_kick_in != kick_reg) ? 16'h0000
                                                           : calm_cnt_reg + 16'h0001;
            kick_reg     <= watchdog_kick_in;
        end
    end
    chk_od_inverse: assert property (reset_high_oe_n == !reset_out_n && !reset_high_out)
        else $error("open-drain reset not inverse");
    chk_hold_length: assert property ($rose(reset_out_n) |-> low_cnt_reg >= HOLD_CYC)
        else $error("reset released early");
    chk_wdog_steady: assert property ($fell(reset_out_n) && !supply_below_reset_in && manual_reset_n |-> calm_cnt_reg >= WDOG_CYC)
        else $error("watchdog reset without steady kick");
    chk_supply_low: assert property (supply_below_reset_in[*6] |-> !reset_out_n)
        else $error("reset high with low supply");
    chk_manual_low: assert property (!manual_reset_n[*6] |-> !reset_out_n)
        else $error("reset high with manual low");
    chk_pf_forced: assert property (supply_below_switchover_in[*6] |-> !powerfail_flag_n)
        else $error("power-fail flag not forced");
    chk_pf_follow: assert property ((!supply_below_switchover_in && $stable(powerfail_sense_in))[*7] |-> powerfail_flag_n == powerfail_sense_in)
        else $error("power-fail flag wrong");
    chk_backup_min: assert property (supply_below_minimum_in[*7] |-> ram_supply_out)
        else $error("no backup below minimum");
    chk_no_entry: assert property ((!supply_below_switchover_in && !supply_below_minimum_in)[*7] |-> !$rose(ram_supply_out))
        else $error("backup entered above switchover");
    chk_keep_backup: assert property (supply_below_reset_in[*8] ##0 ram_supply_out |=> ram_supply_out)
        else $error("main restored below reset level");
    chk_backup_reset: assert property (ram_supply_out |-> !reset_out_n)
        else $error("reset released in backup");
    cover property ($fell(reset_out_n) && manual_reset_n && !supply_below_reset_in);
    cover property ($rose(ram_supply_out));
    cover property ($fell(powerfail_flag_n));
endmodule

bind srw_top srw_properties #(.WDOG_CYC(WDOG_CYC), .HOLD_CYC(HOLD_CYC)) srw_properties_i (.*);

/* srw_cpu_model.sv */
// processor side: toggles the watchdog kick while enabled
`timescale 1ns/1ns
module srw_cpu_model #(
    parameter int GAP = 100
) (
    input  wire logic clk,
    input  wire logic kick_en,
    output logic      watchdog_kick_in
);
    int cnt = 0;
    initial watchdog_kick_in = 1'b0;
    // gap kept well under the watchdog period so jitter cannot trip it
    always @(negedge clk) begin
        cnt = (cnt + 1) % GAP;
        if (kick_en && cnt == 0) watchdog_kick_in <= ~watchdog_kick_in;
    end
endmodule

/* srw_top_tb_top.sv */
// self-checking bench for the supervisor reset watchdog
`timescale 1ns/1ns
module srw_top_tb_top;
    localparam int WD = 200;
    localparam int HD = 50;
    logic        clk = 1'b0, rst_n = 1'b0, kick_en = 1'b0;
    logic        b_rst = 1'b0, b_sw = 1'b0, b_bat = 1'b0, b_min = 1'b0;
    logic        sense = 1'b1, mr_n = 1'b1;
    logic        kick, rst_o_n, hi_o, hi_oe_n, pfo_n, ram;
    logic [15:0] n;
    int          mismatches = 0, checks = 0, cyc = 0;
    always #25 clk = ~clk;
    srw_top #(.WDOG_CYC(WD), .HOLD_CYC(HD)) srw_top_i (
        .clk(clk), .rst_n(rst_n), .supply_below_reset_in(b_rst),
        .supply_below_switchover_in(b_sw), .supply_below_backup_in(b_bat),
        .supply_below_minimum_in(b_min), .powerfail_sense_in(sense),
        .watchdog_kick_in(kick), .manual_reset_n(mr_n),
        .reset_out_n(rst_o_n), .reset_high_out(hi_o),
        .reset_high_oe_n(hi_oe_n), .powerfail_flag_n(pfo_n),
        .ram_supply_out(ram));
    srw_cpu_model srw_cpu_model_i (.clk(clk), .kick_en(kick_en),
        .watchdog_kick_in(kick));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rng(input logic [15:0] lo);
        cmp(16'(n >= lo && n <= lo + 16'd10), 16'h0001);
    endtask
    task automatic dly(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wait_rst(input logic v, input int lim);
        n = 16'h0000;
        while (rst_o_n !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_power;
        dly(12);
        rst_n = 1'b1;
        kick_en = 1'b1;
        wait_rst(1'b1, HD + 20);
        rng(HD);
        cmp(16'({hi_oe_n, hi_o}), 16'h0000);
    endtask
    task automatic t_kick;
        wait_rst(1'b0, 600);
        cmp(n, 16'd600);
    endtask
    task automatic t_wdog;
        @(kick);
        kick_en = 1'b0;
        wait_rst(1'b0, WD + 20);
        rng(WD);
        cmp(16'(hi_oe_n), 16'h0001);
        wait_rst(1'b1, HD + 20);
        rng(HD);
        wait_rst(1'b0, WD + 20);
        rng(WD);
        kick_en = 1'b1;
        wait_rst(1'b1, HD + 20);
    endtask
    task automatic t_restart(input logic man);
        repeat (2) begin
            if (man) mr_n = 1'b0;
            else b_rst = 1'b1;
            dly(10);
            cmp(16'(rst_o_n), 16'h0000);
            mr_n = 1'b1;
            b_rst = 1'b0;
            dly(20);
        end
        wait_rst(1'b1, HD + 20);
        rng(HD - 20);
    endtask
    task automatic t_pf;
        b_bat = 1'b1;
        dly(8);
        cmp(16'({pfo_n, ram}), 16'h0002);
        sense = 1'b0;
        dly(8);
        cmp(16'(pfo_n), 16'h0000);
        {sense, b_sw, b_bat} = 3'b110;
        dly(8);
        cmp(16'({pfo_n, ram}), 16'h0000);
        b_sw = 1'b0;
        dly(8);
        cmp(16'(pfo_n), 16'h0001);
    endtask
    task automatic t_backup;
        {b_rst, b_sw, b_bat} = 3'b111;
        dly(8);
        cmp(16'({ram, rst_o_n, hi_oe_n}), 16'h0005);
        {b_sw, b_bat} = 2'b00;
        dly(8);
        cmp(16'(ram), 16'h0001);
        b_rst = 1'b0;
        dly(8);
        cmp(16'(ram), 16'h0000);
        {b_rst, b_min} = 2'b11;
        dly(8);
        cmp(16'(ram), 16'h0001);
        {b_rst, b_min} = 2'b00;
        wait_rst(1'b1, HD + 20);
        cmp(16'({ram, rst_o_n}), 16'h0001);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            report_and_stop;
        end
    end
    initial begin
        t_power;
        t_kick;
        t_wdog;
        t_restart(1'b0);
        t_restart(1'b1);
        t_pf;
        t_backup;
        report_and_stop;
    end
endmodule
